// [common/amc_cfg.svh]
// Named constants of the attachment unit message control block.
// Assumes a 100 MHz core clock and a 10 Mb/s serial bit rate.
`ifndef AMC_CFG_SVH
`define AMC_CFG_SVH

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define AMC_CLK_NS 10
`define AMC_BIT_NS 100
`define AMC_BIT_CYC (`AMC_BIT_NS / `AMC_CLK_NS)
`define AMC_TEST_DLY_NS 1000
`define AMC_TEST_DLY_CYC (`AMC_TEST_DLY_NS / `AMC_CLK_NS)
`define AMC_TEST_BITS 10
`define AMC_TEST_CYC (`AMC_TEST_BITS * `AMC_BIT_CYC)
`define AMC_JAB_MS 50
`define AMC_NS_PER_MS 1000000
`define AMC_JAB_CYC (`AMC_JAB_MS * `AMC_NS_PER_MS / `AMC_CLK_NS)

// ----------------------------------------------------------------------
// Register map
// ----------------------------------------------------------------------
`define AMC_OFS_CTRL 32'h0000_0000
`define AMC_OFS_STAT 32'h0000_0004
`define AMC_CTRL_ISO 0
`define AMC_STAT_TX 0
`define AMC_STAT_COLL 1
`define AMC_STAT_JAB 2
`define AMC_STAT_ISO 3
`define AMC_STAT_SQE 4
`define AMC_WORD_ZERO 32'h0000_0000
`define AMC_HTRANS_ACT 1
`define AMC_HRESP_OKAY 1'b0
`define AMC_CNT_ZERO 8'h00
`define AMC_JAB_ZERO 32'h0000_0000

`endif

// [common/amc_pkg.sv]
// Types of the attachment unit message control block.
// Assumes the constants header is not needed by users of these types.
package amc_pkg;

   // Abstract symbol classes exchanged with the line coder.
   typedef enum logic [1:0] {
      AMC_SYM_IDLE = 2'b00,
      AMC_SYM_ZERO = 2'b01,
      AMC_SYM_ONE = 2'b10,
      AMC_SYM_CPAT = 2'b11
   } amc_sym_t;

   typedef enum logic [1:0] {
      AMC_SQE_IDLE = 2'b00,
      AMC_SQE_WAIT = 2'b01,
      AMC_SQE_TEST = 2'b10
   } amc_sqe_t;

   typedef struct packed {
      logic hsel;
      logic [1:0] htrans;
      logic [31:0] haddr;
      logic hwrite;
      logic [2:0] hsize;
      logic [31:0] hwdata;
      logic hready;
   } amc_ahb_req_t;

   typedef struct packed {
      logic [31:0] hrdata;
      logic hreadyout;
      logic hresp;
   } amc_ahb_rsp_t;

   typedef struct packed {
      amc_sqe_t quality_error_indication;
      logic [7:0] cnt;
      logic [31:0] jab_cnt;
      logic jabbered;
      logic tx_active;
      logic collision;
      amc_sym_t rx_sym;
      amc_sym_t stat_sym;
      logic med_bit;
      logic drv_en;
      logic pos_dis;
      logic ctrl_iso;
      logic wr_pend;
      logic [31:0] wr_addr;
      logic [31:0] rdata;
   } amc_state_t;

endpackage : amc_pkg

// [src/amc_top.sv]
// Message and control logic of a coaxial trunk attachment unit, facing the station.
// Assumes separate line coders turn symbol classes into phase-coded circuits,
// and an analogue front end reports receive bits and collision levels.
//
// Overview of operation
// R1: Data symbols on transmit circuit mean output.
// R2: Idle on control-out gives nonintrusive state.
// R3: Collision pattern on control-out isolates transmitter.
// R4: Received zero or one sent as data symbol.
// R5: Received data forwarded without retiming.
// R6: No received data means idle on receive circuit.
// R7: Status circuit idle unless quality error sent.
// R8: No quality error with one transmitter.
// R9: Quality error when remote collision is conclusive.
// R10: Collision while transmitting raises quality error.
// R11: Test sequence after every output frame.
// R12: Jabber inhibit raises quality error.
// R13: Error within 9 bits, removed within 20.
// R14: Quality error is collision pattern on status.
// R15: Quality error works regardless of station output.
// R16: Positive disable and release of transmitter.
// R17: Driver enable and disable of data path.
// R18: Collision and no-collision indications kept.
// R19: Test starts 0.6-1.6 us, lasts 10 bits.
// R20: Jabber window between 20 and 150 ms.
// R21: Isolate within 20 ms, receive path untouched.
// R22: Symbols handled as abstract classes.
`timescale 1ns/10ps
`default_nettype none
`include "amc_cfg.svh"

module amc_top
#(
   parameter int unsigned JAB_CYC = `AMC_JAB_CYC
)
(
   // Clock and reset
   input wire logic clock_in,
   input wire logic rst_in,
   // Register bus
   input wire amc_pkg::amc_ahb_req_t ahb_in,
   output amc_pkg::amc_ahb_rsp_t ahb_out,
   // Station transmit side
   input wire amc_pkg::amc_sym_t transmit_data_circuit_in,
   input wire amc_pkg::amc_sym_t control_out_circuit_in,
   // Station receive side
   output amc_pkg::amc_sym_t receive_data_circuit_out,
   output amc_pkg::amc_sym_t status_in_circuit_out,
   // Medium side
   input wire logic rx_valid_in,
   input wire logic rx_bit_in,
   input wire logic coll_det_in,
   input wire logic remote_multi_in,
   output logic med_bit_out,
   output logic driver_enable_out,
   output logic positive_disable_out,
   output logic collision_out,
   output logic no_collision_out
);
   import amc_pkg::*;

   amc_state_t st;
   amc_state_t next_st;
   logic take;
   logic sqe_on;
   logic [1:0] wr_hit;
   logic [1:0] rd_hit;

   // ----------------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------------
   // Returns {status hit, control hit} for a byte address.
   function automatic logic [1:0] amc_decode(input logic [31:0] addr);
      amc_decode = {addr == `AMC_OFS_STAT, addr == `AMC_OFS_CTRL};
   endfunction : amc_decode

   function automatic logic amc_is_data(input amc_sym_t sym);
      amc_is_data = (sym == AMC_SYM_ZERO) || (sym == AMC_SYM_ONE);
   endfunction : amc_is_data

   // ----------------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------------
   always_comb
   begin
      next_st = st;
      take = ahb_in.hsel && ahb_in.htrans[`AMC_HTRANS_ACT] && ahb_in.hready;
      wr_hit = amc_decode(st.wr_addr);
      rd_hit = amc_decode(ahb_in.haddr);
      next_st.tx_active = amc_is_data(transmit_data_circuit_in); // see R1 see R22
      // Isolate message or register isolate engages positive disable; idle on control-out releases it only while the register isolate is clear.
      next_st.pos_dis = (control_out_circuit_in == AMC_SYM_CPAT) || st.ctrl_iso; // see R2 see R3 see R16 see R21
      // The isolate message doubles as the jabber reset.
      if (next_st.pos_dis)
      begin
         next_st.jabbered = 1'b0;
         next_st.jab_cnt = `AMC_JAB_ZERO;
      end
      else if (next_st.tx_active && !st.jabbered)
      begin
         if (st.jab_cnt == 32'(JAB_CYC - 1))
         begin
            next_st.jabbered = 1'b1; // see R20
         end
         else
         begin
            next_st.jab_cnt = st.jab_cnt + 32'd1;
         end
      end
      else if (!next_st.tx_active)
      begin
         next_st.jab_cnt = `AMC_JAB_ZERO;
      end
      next_st.drv_en = next_st.tx_active && !next_st.jabbered && !next_st.pos_dis; // see R17 see R20
      next_st.med_bit = (transmit_data_circuit_in == AMC_SYM_ONE); // see R1
      // Own collision level while driving, remote conclusive level otherwise.
      next_st.collision = next_st.drv_en ? coll_det_in : remote_multi_in; // see R9 see R10 see R18
      case (st.quality_error_indication)
         AMC_SQE_IDLE:
         begin
            if (st.tx_active && !next_st.tx_active)
            begin
               next_st.quality_error_indication = AMC_SQE_WAIT; // see R11
               next_st.cnt = 8'(`AMC_TEST_DLY_CYC - 1);
            end
         end
         AMC_SQE_WAIT:
         begin
            if (st.cnt == `AMC_CNT_ZERO)
            begin
               next_st.quality_error_indication = AMC_SQE_TEST; // see R19
               next_st.cnt = 8'(`AMC_TEST_CYC - 1);
            end
            else
            begin
               next_st.cnt = st.cnt - 8'd1;
            end
         end
         AMC_SQE_TEST:
         begin
            if (st.cnt == `AMC_CNT_ZERO)
            begin
               next_st.quality_error_indication = AMC_SQE_IDLE;
            end
            else
            begin
               next_st.cnt = st.cnt - 8'd1;
            end
         end
         default:
         begin
            next_st.quality_error_indication = AMC_SQE_IDLE;
            next_st.cnt = `AMC_CNT_ZERO;
         end
      endcase
      // No other source, so a lone transmitter raises the error only through jabber or the test sequence.
      sqe_on = next_st.collision || next_st.jabbered || (next_st.quality_error_indication == AMC_SQE_TEST); // see R8 see R12 see R15
      next_st.stat_sym = sqe_on ? AMC_SYM_CPAT : AMC_SYM_IDLE; // see R7 see R13 see R14
      // One register stage only; the medium's bit timing passes straight through.
      next_st.rx_sym = !rx_valid_in ? AMC_SYM_IDLE : (rx_bit_in ? AMC_SYM_ONE : AMC_SYM_ZERO); // see R4 see R5 see R6
      // Bus slave: address phase captured, write lands in the data phase.
      next_st.wr_pend = take && ahb_in.hwrite;
      if (take)
      begin
         next_st.wr_addr = ahb_in.haddr;
      end
      if (st.wr_pend && wr_hit[0])
      begin
         next_st.ctrl_iso = ahb_in.hwdata[`AMC_CTRL_ISO];
      end
      if (take && !ahb_in.hwrite)
      begin
         next_st.rdata = `AMC_WORD_ZERO;
         if (rd_hit[0])
         begin
            next_st.rdata[`AMC_CTRL_ISO] = st.ctrl_iso;
         end
         if (rd_hit[1])
         begin
            next_st.rdata[`AMC_STAT_TX] = st.tx_active;
            next_st.rdata[`AMC_STAT_COLL] = st.collision;
            next_st.rdata[`AMC_STAT_JAB] = st.jabbered;
            next_st.rdata[`AMC_STAT_ISO] = st.pos_dis;
            next_st.rdata[`AMC_STAT_SQE] = (st.stat_sym == AMC_SYM_CPAT);
         end
      end
   end

   // ----------------------------------------------------------------------
   // State register and outputs
   // ----------------------------------------------------------------------
   always_ff @(posedge clock_in)
   begin
      if (rst_in)
      begin
         st <= '0;
      end
      else
      begin
         st <= next_st;
      end
   end

   assign ahb_out = '{hrdata: st.rdata, hreadyout: 1'b1, hresp: `AMC_HRESP_OKAY};
   assign receive_data_circuit_out = st.rx_sym;
   assign status_in_circuit_out = st.stat_sym;
   assign med_bit_out = st.med_bit;
   assign driver_enable_out = st.drv_en;
   assign positive_disable_out = st.pos_dis;
   assign collision_out = st.collision;
   assign no_collision_out = !st.collision; // see R18

   // ----------------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------------
   AST_RX_DATA: assert property (@(posedge clock_in) disable iff (rst_in) // see R4
      rx_valid_in |-> ##1 (receive_data_circuit_out == ($past(rx_bit_in) ? AMC_SYM_ONE : AMC_SYM_ZERO)))
      else $error("Received bit not forwarded as data symbol.");

   AST_RX_IDLE: assert property (@(posedge clock_in) disable iff (rst_in) // see R6
      !rx_valid_in |-> ##1 (receive_data_circuit_out == AMC_SYM_IDLE))
      else $error("Receive circuit not idle without data.");

   AST_SQE_ON: assert property (@(posedge clock_in) disable iff (rst_in) // see R13
      (driver_enable_out && coll_det_in && amc_is_data(transmit_data_circuit_in)
      && control_out_circuit_in != AMC_SYM_CPAT && !st.ctrl_iso) |-> ##[1:2] (status_in_circuit_out == AMC_SYM_CPAT))
      else $error("Collision not signalled in time.");

   AST_SQE_QUIET: assert property (@(posedge clock_in) disable iff (rst_in) // see R8
      (!coll_det_in && !remote_multi_in && !next_st.jabbered && next_st.quality_error_indication != AMC_SQE_TEST)
      |=> (status_in_circuit_out == AMC_SYM_IDLE))
      else $error("Quality error raised without cause.");

   AST_ISOLATE: assert property (@(posedge clock_in) disable iff (rst_in) // see R3
      (control_out_circuit_in == AMC_SYM_CPAT) |-> ##1 (positive_disable_out && !driver_enable_out))
      else $error("Isolate did not disable the transmitter.");

   AST_NORMAL: assert property (@(posedge clock_in) disable iff (rst_in) // see R2
      (control_out_circuit_in == AMC_SYM_IDLE && !st.ctrl_iso) |-> ##1 !positive_disable_out)
      else $error("Normal message did not release the transmitter.");

   AST_TEST_START: assert property (@(posedge clock_in) disable iff (rst_in) // see R19
      $fell(st.tx_active) && st.quality_error_indication == AMC_SQE_WAIT |-> ##[59:160] (status_in_circuit_out == AMC_SYM_CPAT))
      else $error("Test sequence did not start in its window.");

   AST_TEST_LEN: assert property (@(posedge clock_in) disable iff (rst_in) // see R11
      $rose(st.quality_error_indication == AMC_SQE_TEST) |-> ##99 (st.quality_error_indication == AMC_SQE_TEST) ##1 (st.quality_error_indication != AMC_SQE_TEST))
      else $error("Test sequence length wrong.");

   AST_JABBER: assert property (@(posedge clock_in) disable iff (rst_in) // see R12
      st.jabbered |-> (status_in_circuit_out == AMC_SYM_CPAT && !driver_enable_out))
      else $error("Jabber inhibit not signalled.");

   AST_TX_PASS: assert property (@(posedge clock_in) disable iff (rst_in) // see R17
      (transmit_data_circuit_in == AMC_SYM_ONE && control_out_circuit_in != AMC_SYM_CPAT && !st.ctrl_iso && !st.jabbered)
      |-> ##1 (med_bit_out && (driver_enable_out || st.jabbered)))
      else $error("Output data not driven to the medium.");

   // ----------------------------------------------------------------------
   // Rule checks
   // ----------------------------------------------------------------------
   AST_RX_FOLLOW: assert property (@(posedge clock_in) disable iff (rst_in) // see R5
      (rx_valid_in && $past(rx_valid_in) && $changed(rx_bit_in))
      |=> $changed(receive_data_circuit_out))
      else $error("Received bit change not passed straight on.");

   AST_RX_CLASS: assert property (@(posedge clock_in) disable iff (rst_in) // see R22
      (receive_data_circuit_out != AMC_SYM_CPAT))
      else $error("Receive circuit carried the collision pattern.");

   AST_STAT_CLASS: assert property (@(posedge clock_in) disable iff (rst_in) // see R7
      (status_in_circuit_out == AMC_SYM_IDLE || status_in_circuit_out == AMC_SYM_CPAT))
      else $error("Status circuit carried a data symbol.");

   AST_SQE_REMOTE: assert property (@(posedge clock_in) disable iff (rst_in) // see R9
      (remote_multi_in && !amc_is_data(transmit_data_circuit_in))
      |=> (status_in_circuit_out == AMC_SYM_CPAT))
      else $error("Remote collision not signalled.");

   AST_SQE_DROP: assert property (@(posedge clock_in) disable iff (rst_in) // see R13
      (!coll_det_in && !remote_multi_in && !st.jabbered && !st.tx_active && st.quality_error_indication == AMC_SQE_IDLE)
      |=> (status_in_circuit_out == AMC_SYM_IDLE))
      else $error("Quality error kept after its cause ended.");

   AST_COLL_PAIR: assert property (@(posedge clock_in) disable iff (rst_in) // see R18
      (collision_out != no_collision_out))
      else $error("Collision indications not complementary.");

   AST_COLL_SIGNAL: assert property (@(posedge clock_in) disable iff (rst_in) // see R10
      collision_out
      |-> (status_in_circuit_out == AMC_SYM_CPAT))
      else $error("Collision without quality error.");

   AST_DRV_IDLE: assert property (@(posedge clock_in) disable iff (rst_in) // see R17
      !amc_is_data(transmit_data_circuit_in)
      |=> !driver_enable_out)
      else $error("Driver left on without output data.");

   AST_DRV_START: assert property (@(posedge clock_in) disable iff (rst_in) // see R17
      (amc_is_data(transmit_data_circuit_in) && !st.tx_active && !st.jabbered
      && control_out_circuit_in != AMC_SYM_CPAT && !st.ctrl_iso) |=> driver_enable_out)
      else $error("Driver not enabled at frame start.");

   AST_DRV_SAFE: assert property (@(posedge clock_in) disable iff (rst_in) // see R16
      driver_enable_out
      |-> !positive_disable_out)
      else $error("Driver enabled while positively disabled.");

   AST_ISO_HOLD: assert property (@(posedge clock_in) disable iff (rst_in) // see R16
      st.ctrl_iso
      |=> positive_disable_out)
      else $error("Register isolate did not disable the transmitter.");

   AST_ISO_RX: assert property (@(posedge clock_in) disable iff (rst_in) // see R21
      (control_out_circuit_in == AMC_SYM_CPAT && rx_valid_in && rx_bit_in)
      |=> (receive_data_circuit_out == AMC_SYM_ONE))
      else $error("Isolate disturbed the receive path.");

   AST_ISO_COLL: assert property (@(posedge clock_in) disable iff (rst_in) // see R21
      (control_out_circuit_in == AMC_SYM_CPAT && remote_multi_in)
      |=> collision_out)
      else $error("Isolate disturbed the collision path.");

   AST_JAB_SET: assert property (@(posedge clock_in) disable iff (rst_in) // see R20
      (driver_enable_out && st.jab_cnt == 32'(JAB_CYC - 1) && amc_is_data(transmit_data_circuit_in)
      && control_out_circuit_in != AMC_SYM_CPAT && !st.ctrl_iso) |=> (st.jabbered && !driver_enable_out))
      else $error("Jabber window not enforced.");

   AST_JAB_HOLD: assert property (@(posedge clock_in) disable iff (rst_in) // see R12
      (st.jabbered && control_out_circuit_in != AMC_SYM_CPAT && !st.ctrl_iso)
      |=> st.jabbered)
      else $error("Jabber inhibit released without isolate.");

   AST_JAB_RESET: assert property (@(posedge clock_in) disable iff (rst_in) // see R3
      positive_disable_out
      |-> !st.jabbered)
      else $error("Isolate did not reset the jabber inhibit.");

   AST_MED_ONE: assert property (@(posedge clock_in) disable iff (rst_in) // see R1
      (transmit_data_circuit_in == AMC_SYM_ONE)
      |=> med_bit_out)
      else $error("Output one not passed to the medium.");

   AST_MED_ZERO: assert property (@(posedge clock_in) disable iff (rst_in) // see R1
      (transmit_data_circuit_in != AMC_SYM_ONE)
      |=> !med_bit_out)
      else $error("Medium bit high without output one.");

   AST_TEST_ARM: assert property (@(posedge clock_in) disable iff (rst_in) // see R11
      (st.tx_active && !amc_is_data(transmit_data_circuit_in) && st.quality_error_indication == AMC_SQE_IDLE)
      |=> (st.quality_error_indication == AMC_SQE_WAIT))
      else $error("Frame end did not arm the test sequence.");

   AST_CTRL_WRITE: assert property (@(posedge clock_in) disable iff (rst_in) // see R16
      (st.wr_pend && st.wr_addr == `AMC_OFS_CTRL)
      |=> (st.ctrl_iso == $past(ahb_in.hwdata[`AMC_CTRL_ISO])))
      else $error("Control write did not land.");

   AST_TEST_SIGNAL: assert property (@(posedge clock_in) disable iff (rst_in) // see R14
      (st.quality_error_indication == AMC_SQE_TEST)
      |-> (status_in_circuit_out == AMC_SYM_CPAT))
      else $error("Test sequence not shown on the status circuit.");

   AST_NO_CAUSE: assert property (@(posedge clock_in) disable iff (rst_in) // see R8
      (!collision_out && !st.jabbered && st.quality_error_indication != AMC_SQE_TEST)
      |-> (status_in_circuit_out == AMC_SYM_IDLE))
      else $error("Quality error shown with no cause.");

   AST_TX_SEEN: assert property (@(posedge clock_in) disable iff (rst_in) // see R1
      amc_is_data(transmit_data_circuit_in)
      |=> st.tx_active)
      else $error("Output data not recognised.");

   AST_BUS_OKAY: assert property (@(posedge clock_in) disable iff (rst_in)
      (ahb_out.hreadyout && ahb_out.hresp == `AMC_HRESP_OKAY))
      else $error("Bus response not ready and okay.");

endmodule : amc_top

`default_nettype wire

// [sim/amc_station.sv]
// Station model: drives transmit symbols and control messages.
// Assumes it shares the clock of the unit.
`timescale 1ns/10ps
`default_nettype none
module amc_station
(
   // Clock and commands
   input wire logic clock_in,
   input wire logic send_in,
   input wire logic bit_in,
   input wire logic iso_in,
   // Station circuits
   output amc_pkg::amc_sym_t tx_out,
   output amc_pkg::amc_sym_t co_out
);
   import amc_pkg::*;
   initial tx_out = AMC_SYM_IDLE;
   initial co_out = AMC_SYM_IDLE;
   always @(posedge clock_in)
   begin
      tx_out <= !send_in ? AMC_SYM_IDLE : (bit_in ? AMC_SYM_ONE : AMC_SYM_ZERO);
      co_out <= iso_in ? AMC_SYM_CPAT : AMC_SYM_IDLE;
   end
endmodule : amc_station
`default_nettype wire

// [sim/amc_top_tb.sv]
// Self-checking bench of the attachment unit message control block.
// Assumes the station model and the unit share one 100 MHz clock.
`timescale 1ns/10ps
`default_nettype none
`include "amc_cfg.svh"
module amc_top_tb;
   import amc_pkg::*;
   typedef struct packed {logic v; logic b; logic m; amc_sym_t rd; amc_sym_t st;} amc_row_t;
   // Short jabber window so the inhibit shows within a few hundred cycles.
   localparam int JAB = 200;
   localparam amc_row_t ROWS [4] = '{'{1'h0, 1'h0, 1'h0, AMC_SYM_IDLE, AMC_SYM_IDLE},
      '{1'h1, 1'h0, 1'h0, AMC_SYM_ZERO, AMC_SYM_IDLE}, '{1'h1, 1'h1, 1'h0, AMC_SYM_ONE, AMC_SYM_IDLE},
      '{1'h0, 1'h0, 1'h1, AMC_SYM_IDLE, AMC_SYM_CPAT}};
   logic clock_in = 1'h0;
   logic rst_in = 1'h1;
   logic send = 1'h0, bitv = 1'h1, iso = 1'h0, rx_valid = 1'h0, rx_bit = 1'h0, coll = 1'h0, remote = 1'h0;
   logic med_bit, drv_en, pos_dis, coll_out, no_coll;
   logic [31:0] rd;
   amc_sym_t tx_sym, co_sym, rd_sym, st_sym;
   amc_ahb_req_t req = '0;
   amc_ahb_req_t req_w;
   amc_ahb_rsp_t rsp;
   int fail_count = 0;
   int n_tests = 0;
   int cyc = 0;
   int n;

   initial
   begin
      forever #5 clock_in = ~clock_in;
   end
   always_comb
   begin
      req_w = req;
      req_w.hready = rsp.hreadyout;
   end

   amc_station stn_u (.clock_in(clock_in), .send_in(send), .bit_in(bitv), .iso_in(iso), .tx_out(tx_sym),
      .co_out(co_sym));
   amc_top #(.JAB_CYC(JAB)) dut_u (.clock_in(clock_in), .rst_in(rst_in), .ahb_in(req_w), .ahb_out(rsp),
      .transmit_data_circuit_in(tx_sym), .control_out_circuit_in(co_sym), .receive_data_circuit_out(rd_sym),
      .status_in_circuit_out(st_sym), .rx_valid_in(rx_valid), .rx_bit_in(rx_bit), .coll_det_in(coll),
      .remote_multi_in(remote), .med_bit_out(med_bit), .driver_enable_out(drv_en),
      .positive_disable_out(pos_dis), .collision_out(coll_out), .no_collision_out(no_coll));

   task automatic give_verdict();
      $display("Comparisons %0d mismatches %0d", n_tests, fail_count);
      if (fail_count == 0 && n_tests > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : give_verdict
   task automatic note(input logic ok, input string what);
      n_tests++;
      if (ok !== 1'h1)
      begin
         fail_count++;
         $display("MISMATCH %0t %s", $time, what);
      end
   endtask : note
   task automatic check_sym(input amc_sym_t got, input amc_sym_t exp, input string what);
      note(got === exp, what);
   endtask : check_sym
   task automatic check_val(input logic [31:0] got, input logic [31:0] exp, input string what);
      note(got === exp, what);
   endtask : check_val
   task automatic tick(input int k);
      repeat (k) @(posedge clock_in);
      #1;
   endtask : tick
   task automatic wait_st(input amc_sym_t exp, input int lim);
      n = 0;
      while (st_sym !== exp && n < lim)
      begin
         tick(1);
         n++;
      end
   endtask : wait_st
   task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] wd, output logic [31:0] rdv);
      @(posedge clock_in);
      req <= '{hsel:1'h1, htrans:2'h2, haddr:a, hwrite:wr, hsize:3'h2, hwdata:32'h0000_0000, hready:1'h1};
      do @(posedge clock_in); while (rsp.hreadyout !== 1'h1);
      req.htrans <= 2'h0;
      req.hwdata <= wd;
      do @(posedge clock_in); while (rsp.hreadyout !== 1'h1);
      rdv = rsp.hrdata;
      req.hsel <= 1'h0;
   endtask : ahb

   always @(posedge clock_in)
   begin
      cyc <= cyc + 1;
      if (cyc == 5000)
      begin
         fail_count++;
         give_verdict();
      end
   end

   initial
   begin
      repeat (12) @(posedge clock_in);
      rst_in <= 1'h0;
      tick(1);
      check_sym(rd_sym, AMC_SYM_IDLE, "reset rx");
      check_sym(st_sym, AMC_SYM_IDLE, "reset status");
      check_val(32'({drv_en, pos_dis, no_coll}), 32'h0000_0001, "reset levels");
      $display("reset done");
      foreach (ROWS[i])
      begin
         @(posedge clock_in);
         rx_valid <= ROWS[i].v;
         rx_bit <= ROWS[i].b;
         remote <= ROWS[i].m;
         tick(1);
         check_sym(rd_sym, ROWS[i].rd, "rx symbol");
         tick(2);
         check_sym(st_sym, ROWS[i].st, "status symbol");
         check_val(32'({coll_out, no_coll}), 32'({ROWS[i].m, !ROWS[i].m}), "collision levels");
      end
      @(posedge clock_in);
      remote <= 1'h0;
      wait_st(AMC_SYM_IDLE, 199);
      check_sym(st_sym, AMC_SYM_IDLE, "error removed");
      $display("rows done");
      @(posedge clock_in);
      send <= 1'h1;
      tick(20);
      check_val(32'({drv_en, med_bit}), 32'h0000_0003, "driving");
      check_sym(st_sym, AMC_SYM_IDLE, "lone sender");
      @(posedge clock_in);
      send <= 1'h0;
      wait_st(AMC_SYM_CPAT, 300);
      check_val(32'(n >= 60 && n <= 161), 32'h0000_0001, "test start");
      wait_st(AMC_SYM_IDLE, 300);
      check_val(32'(n >= 50 && n <= 150), 32'h0000_0001, "test length");
      check_val(32'(drv_en), 32'h0000_0000, "driver off");
      $display("frame done");
      @(posedge clock_in);
      send <= 1'h1;
      tick(5);
      @(posedge clock_in);
      coll <= 1'h1;
      wait_st(AMC_SYM_CPAT, 89);
      check_sym(st_sym, AMC_SYM_CPAT, "collision seen");
      @(posedge clock_in);
      coll <= 1'h0;
      wait_st(AMC_SYM_IDLE, 199);
      check_sym(st_sym, AMC_SYM_IDLE, "collision gone");
      @(posedge clock_in);
      send <= 1'h0;
      tick(300);
      $display("collision done");
      @(posedge clock_in);
      iso <= 1'h1;
      send <= 1'h1;
      rx_valid <= 1'h1;
      rx_bit <= 1'h1;
      remote <= 1'h1;
      tick(5);
      check_val(32'({pos_dis, drv_en}), 32'h0000_0002, "isolated");
      check_sym(rd_sym, AMC_SYM_ONE, "rx under isolate");
      check_val(32'(coll_out), 32'h0000_0001, "collision under isolate");
      @(posedge clock_in);
      iso <= 1'h0;
      send <= 1'h0;
      rx_valid <= 1'h0;
      remote <= 1'h0;
      tick(5);
      check_val(32'(pos_dis), 32'h0000_0000, "released");
      tick(300);
      $display("isolate done");
      @(posedge clock_in);
      send <= 1'h1;
      tick(JAB + 20);
      check_val(32'(drv_en), 32'h0000_0000, "jabber inhibit");
      check_sym(st_sym, AMC_SYM_CPAT, "jabber error");
      @(posedge clock_in);
      send <= 1'h0;
      ahb(1'h1, `AMC_OFS_CTRL, 32'h0000_0001, rd);
      tick(3);
      check_val(32'(pos_dis), 32'h0000_0001, "register isolate");
      ahb(1'h0, `AMC_OFS_STAT, 32'h0000_0000, rd);
      check_val(32'(rd[`AMC_STAT_ISO]), 32'h0000_0001, "status isolate bit");
      ahb(1'h0, `AMC_OFS_CTRL, 32'h0000_0000, rd);
      check_val(rd, 32'h0000_0001, "control readback");
      ahb(1'h0, 32'h0000_0010, 32'h0000_0000, rd);
      check_val(rd, 32'h0000_0000, "unmapped read");
      check_val(32'({rsp.hreadyout, rsp.hresp}), 32'h0000_0002, "bus response");
      ahb(1'h1, `AMC_OFS_CTRL, 32'h0000_0000, rd);
      wait_st(AMC_SYM_IDLE, 300);
      check_sym(st_sym, AMC_SYM_IDLE, "jabber cleared");
      $display("jabber done");
      give_verdict();
   end
endmodule : amc_top_tb
`default_nettype wire
